// ===== sar_ctl_defs.svh
`ifndef SAR_CTL_DEFS_SVH
`define SAR_CTL_DEFS_SVH
// ****************************************
// timing and layout constants
// ****************************************
`define CODE_BITS 12
`define CODE_STEPS 4096
`define WORD_RSV_BIT 15
`define WORD_TAG_HI 14
`define WORD_TAG_LO 13
`define WORD_ALERT_BIT 12
`define WORD_CODE_HI 11
`define WORD_RESULT_RESET 16'h0000
`define CODE_RESET 12'h000
`define CODE_MSB_ONLY 12'h0800
`define STEP_DIV_RESET 4'h0
`define STEP_DIV_LAST 4'h3
`define RESET_MIN_NS 10
`define CLK_PERIOD_NS 10
`define RESET_MIN_CYC (((`RESET_MIN_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define REF_WARMUP_MS 50
`define REF_WARMUP_CYC (`REF_WARMUP_MS * 100000)
`endif

// ===== sar_ctl_pkg.sv
package sar_ctl_pkg;
  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_CONVERT,
    ST_DONE
  } conv_state_t;
endpackage : sar_ctl_pkg

// ===== sar_adc_core_control.sv
// What this block does
// - straight binary 12-bit code, step Vref/4096
// - config low bit 1 selects internal reference
// - internal reference off after power-up
// - auto power-down after every conversion
// - reset low clears registers asynchronously; trigger sync and pd_q load 1
// - 16-bit word sent as two bytes, MSB first
// - conversion timed by internal clock, not serial
// - word: rsv, channel tag, alert, code
// - trigger falling edge holds and starts conversion
`timescale 1ns/100ps
`default_nettype none
`include "sar_ctl_defs.svh"
module sar_adc_core_control (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sample_trigger,
  input wire logic comparator_high,
  input wire logic [1:0] channel_select,
  input wire logic alert_in,
  input wire logic pdown_ref_bit,
  input wire logic pdown_ref_wr,
  input wire logic byte_req,
  output logic [`CODE_BITS-1:0] dac_code,
  output logic hold,
  output logic powered_down,
  output logic reference_internal,
  output logic [15:0] sample_code_word,
  output logic [7:0] byte_out,
  output logic byte_valid,
  output logic conv_done,
  output logic next_power_low
);
  import sar_ctl_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic trig_s1_q, trig_s2_q, trig_s3_q, cmp_s1_q, cmp_s2_q;
  logic trig_fall;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trig_s1_q <= 1'b1;
      trig_s2_q <= 1'b1;
      trig_s3_q <= 1'b1;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      trig_s1_q <= sample_trigger;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      cmp_s1_q <= comparator_high;
      cmp_s2_q <= cmp_s1_q;
    end
  end
  assign trig_fall = trig_s3_q & ~trig_s2_q;

  // ****************************************
  // reference select
  // ****************************************
  logic ref_int_d, ref_int_q;
  always_comb begin
    ref_int_d = ref_int_q;
    if (pdown_ref_wr) begin
      ref_int_d = pdown_ref_bit;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ref_int_q <= 1'b0;
    end else begin
      ref_int_q <= ref_int_d;
    end
  end
  assign reference_internal = ref_int_q;

  // ****************************************
  // conversion engine
  // ****************************************
  conv_state_t st_d, st_q;
  logic [3:0] div_d, div_q;
  logic [3:0] bit_d, bit_q;
  logic [`CODE_BITS-1:0] trial_d, trial_q;
  logic [15:0] word_d, word_q;
  logic [1:0] tag_d, tag_q;
  logic done_d, done_q, npl_d, npl_q;
  logic step;
  assign step = (div_q == `STEP_DIV_LAST);
  always_comb begin
    st_d = st_q;
    div_d = div_q;
    bit_d = bit_q;
    trial_d = trial_q;
    word_d = word_q;
    tag_d = tag_q;
    done_d = 1'b0;
    npl_d = npl_q;
    unique case (st_q)
      ST_SLEEP: begin
        if (trig_fall) begin
          st_d = ST_CONVERT;
          div_d = `STEP_DIV_RESET;
          bit_d = 4'(`CODE_BITS - 1);
          trial_d = `CODE_MSB_ONLY;
          tag_d = channel_select;
        end
      end
      ST_CONVERT: begin
        // internal step divider paces the trials
        div_d = step ? `STEP_DIV_RESET : 4'(div_q + 4'h1);
        if (step) begin
          // keep or drop the trial bit, try the next lower
          if (!cmp_s2_q) begin
            trial_d[bit_q] = 1'b0;
          end
          if (bit_q == 4'h0) begin
            st_d = ST_DONE;
          end else begin
            trial_d[bit_q - 4'h1] = 1'b1;
            bit_d = 4'(bit_q - 4'h1);
          end
        end
      end
      ST_DONE: begin
        word_d = {1'b0, tag_q, alert_in, trial_q};
        done_d = 1'b1;
        npl_d = trig_s2_q;
        st_d = ST_SLEEP;
      end
      default: begin
        st_d = ST_SLEEP;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_SLEEP;
      div_q <= `STEP_DIV_RESET;
      bit_q <= 4'h0;
      trial_q <= `CODE_RESET;
      word_q <= `WORD_RESULT_RESET;
      tag_q <= 2'b00;
      done_q <= 1'b0;
      npl_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      bit_q <= bit_d;
      trial_q <= trial_d;
      word_q <= word_d;
      tag_q <= tag_d;
      done_q <= done_d;
      npl_q <= npl_d;
    end
  end

  logic hold_d, hold_q, pd_d, pd_q;
  always_comb begin
    hold_d = (st_d == ST_CONVERT);
    pd_d = (st_d == ST_SLEEP);
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
      pd_q <= 1'b1;
    end else begin
      hold_q <= hold_d;
      pd_q <= pd_d;
    end
  end
  assign dac_code = trial_q;
  assign hold = hold_q;
  assign powered_down = pd_q;
  assign sample_code_word = word_q;
  assign conv_done = done_q;
  assign next_power_low = npl_q;

  // ****************************************
  // result byte serialiser
  // ****************************************
  logic sel_d, sel_q, bv_d, bv_q;
  logic [7:0] bo_d, bo_q;
  always_comb begin
    sel_d = sel_q;
    bv_d = 1'b0;
    bo_d = bo_q;
    if (done_q) begin
      sel_d = 1'b0;
    end else if (byte_req) begin
      bo_d = sel_q ? word_q[7:0] : word_q[15:8];
      bv_d = 1'b1;
      sel_d = ~sel_q;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
      bv_q <= 1'b0;
      bo_q <= 8'h00;
    end else begin
      sel_q <= sel_d;
      bv_q <= bv_d;
      bo_q <= bo_d;
    end
  end
  assign byte_out = bo_q;
  assign byte_valid = bv_q;

  // ****************************************
  // checks
  // ****************************************
  // counts the cycles that hold has been high
  logic [5:0] hcnt_d, hcnt_q;
  always_comb begin
    hcnt_d = hold_q ? 6'(hcnt_q + 6'h01) : 6'h00;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_q <= 6'h00;
    end else begin
      hcnt_q <= hcnt_d;
    end
  end
  msb_first_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    byte_req && !done_q && !sel_q |=> byte_out == $past(word_q[15:8]))
    else $error("high byte not sent first");
  rsv_zero_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    sample_code_word[`WORD_RSV_BIT] == 1'b0)
    else $error("reserved bit set");
  auto_pd_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    conv_done |-> powered_down)
    else $error("no power-down after conversion");
  start_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    st_q == ST_SLEEP && trig_fall |=> hold ##0 dac_code == `CODE_MSB_ONLY)
    else $error("trigger did not start conversion");
  conv_len_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    $rose(hold) |-> hold [*8])
    else $error("conversion ended early");
  conv_steps_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    $fell(hold) |-> hcnt_q == 6'(`CODE_BITS * (`STEP_DIV_LAST + 4'h1)))
    else $error("conversion length wrong");
  ref_sel_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    pdown_ref_wr |=> reference_internal == $past(pdown_ref_bit))
    else $error("reference select wrong");
  done_pulse_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    conv_done |=> !conv_done)
    else $error("done not a pulse");
  tag_a: assert property (@(posedge mclk)
    disable iff (!rst_n)
    conv_done |-> sample_code_word[`WORD_TAG_HI:`WORD_TAG_LO] == tag_q)
    else $error("channel tag wrong");
endmodule : sar_adc_core_control
`default_nettype wire

// ===== sar_input_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "sar_ctl_defs.svh"
module sar_input_model (
  input wire logic [`CODE_BITS-1:0] dac_code,
  input wire logic [`CODE_BITS-1:0] vin_code,
  output logic comparator_high
);
  // held input as an ideal code: a trial is kept once the input reaches it
  assign comparator_high = (vin_code >= dac_code);
endmodule : sar_input_model
`default_nettype wire

// ===== sar_adc_core_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sar_adc_core_control_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sample_trigger = 1'b1;
  logic alert_in = 1'b0;
  logic pdown_ref_bit = 1'b0;
  logic pdown_ref_wr = 1'b0;
  logic byte_req = 1'b0;
  logic [1:0] channel_select = 2'h0;
  logic [11:0] vin_code = 12'h000;
  logic [11:0] dac_code;
  logic [15:0] word;
  logic [7:0] byte_out;
  logic comparator_high, hold, powered_down, reference_internal;
  logic byte_valid, conv_done, next_power_low;
  int n_errors = 0;
  int n_checks = 0;
  // input code, channel, alert, pin level at end, word, power hint
  typedef struct {
    logic [11:0] v;
    logic [1:0] ch;
    logic al;
    logic lv;
    logic [15:0] w;
    logic np;
  } row_t;
  row_t rows[4] = '{'{12'h001, 2'h0, 1'b0, 1'b0, 16'h0001, 1'b0},
                    '{12'hfff, 2'h1, 1'b1, 1'b1, 16'h3fff, 1'b1},
                    '{12'h800, 2'h2, 1'b0, 1'b1, 16'h4800, 1'b1},
                    '{12'h5a3, 2'h3, 1'b1, 1'b0, 16'h75a3, 1'b0}};
  logic [15:0] e;

  always #5 mclk = ~mclk;

  sar_input_model sar_input_model_i (.dac_code(dac_code),
    .vin_code(vin_code), .comparator_high(comparator_high));
  sar_adc_core_control sar_adc_core_control_i (.mclk(mclk), .rst_n(rst_n),
    .sample_trigger(sample_trigger), .comparator_high(comparator_high),
    .channel_select(channel_select), .alert_in(alert_in),
    .pdown_ref_bit(pdown_ref_bit), .pdown_ref_wr(pdown_ref_wr),
    .byte_req(byte_req), .dac_code(dac_code), .hold(hold),
    .powered_down(powered_down), .reference_internal(reference_internal),
    .sample_code_word(word), .byte_out(byte_out), .byte_valid(byte_valid),
    .conv_done(conv_done), .next_power_low(next_power_low));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task complete_run;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task set_ref(input logic b);
    @(negedge mclk) pdown_ref_bit = b;
    pdown_ref_wr = 1'b1;
    @(negedge mclk) pdown_ref_wr = 1'b0;
  endtask : set_ref

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    chk({15'h0000, powered_down}, 16'h0001);
    chk({15'h0000, reference_internal}, 16'h0000);
    chk(word, 16'h0000);
    foreach (rows[i]) begin
      e = rows[i].w;
      @(negedge mclk);
      vin_code = rows[i].v;
      channel_select = rows[i].ch;
      alert_in = rows[i].al;
      sample_trigger = 1'b0;
      repeat (6) @(negedge mclk);
      chk({14'h0000, hold, powered_down}, 16'h0002);
      sample_trigger = rows[i].lv;
      for (int k = 0; k < 100 && conv_done !== 1'b1; k++) begin
        @(negedge mclk);
      end
      chk({15'h0000, conv_done}, 16'h0001);
      chk(word, e);
      @(negedge mclk);
      chk({14'h0000, hold, powered_down}, 16'h0001);
      chk({15'h0000, next_power_low}, {15'h0000, rows[i].np});
      sample_trigger = 1'b1;
      byte_req = 1'b1;
      @(negedge mclk);
      chk({7'h00, byte_valid, byte_out}, {8'h01, e[15:8]});
      @(negedge mclk);
      chk({7'h00, byte_valid, byte_out}, {8'h01, e[7:0]});
      byte_req = 1'b0;
    end
    // a second fall in mid conversion must not restart it
    @(negedge mclk);
    sample_trigger = 1'b0;
    repeat (10) @(negedge mclk);
    sample_trigger = 1'b1;
    repeat (4) @(negedge mclk);
    sample_trigger = 1'b0;
    repeat (37) @(negedge mclk);
    chk({15'h0000, conv_done}, 16'h0000);
    @(negedge mclk);
    chk({15'h0000, conv_done}, 16'h0001);
    chk(word, 16'h75a3);
    repeat (6) @(negedge mclk);
    chk({14'h0000, hold, powered_down}, 16'h0001);
    sample_trigger = 1'b1;
    set_ref(1'b1);
    chk({15'h0000, reference_internal}, 16'h0001);
    set_ref(1'b0);
    chk({15'h0000, reference_internal}, 16'h0000);
    set_ref(1'b1);
    // reset in mid conversion; hold, power-down, reference select and word
    // must return to their reset values
    @(negedge mclk);
    sample_trigger = 1'b0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b0;
    #1;
    chk({14'h0000, hold, powered_down}, 16'h0001);
    chk({15'h0000, reference_internal}, 16'h0000);
    chk(word, 16'h0000);
    @(negedge mclk);
    rst_n = 1'b1;
    sample_trigger = 1'b1;
    repeat (6) @(negedge mclk);
    chk({14'h0000, hold, powered_down}, 16'h0001);
    chk({15'h0000, reference_internal}, 16'h0000);
    complete_run();
  end

  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
endmodule : sar_adc_core_control_tb
`default_nettype wire
